//--- fti_pkg.sv
// Package of constants and types for the flash time interpolator
package fti_pkg;
  // ==========================================================
  // Chain geometry
  localparam int unsigned FTI_STAGES     = 9;
  localparam int unsigned FTI_SUBPERIODS = 10;
  localparam int unsigned FTI_RES_W      = 4;
  // ==========================================================
  // Timing figures in picoseconds
  localparam int unsigned FTI_REF_PERIOD_PS = 2000;
  localparam int unsigned FTI_STEP_PS       = 200;
  localparam int unsigned FTI_LEAD_NOM_PS   = 750;
  localparam int unsigned FTI_LEAD_TOL_PS   = 700;
  localparam int unsigned FTI_CLK_PS        = 20000;
  // Sub-period steps per reference period
  localparam int unsigned FTI_STEPS = FTI_REF_PERIOD_PS / FTI_STEP_PS;
  // Strobe lead as whole clock cycles, at least one
  localparam int unsigned FTI_LEAD_CYC =
    (FTI_LEAD_NOM_PS + FTI_CLK_PS - 1) / FTI_CLK_PS;
  // ==========================================================
  // Types
  typedef logic [FTI_STAGES-1:0] fti_therm_t;
  typedef logic [FTI_RES_W-1:0]  fti_result_t;
  typedef enum logic [1:0] {
    FTI_IDLE  = 2'b00,
    FTI_ARMED = 2'b01,
    FTI_RACE  = 2'b10
  } fti_state_t;
  localparam fti_result_t FTI_RES_ZERO = 4'h0;
endpackage : fti_pkg

//--- fti_encoder.sv
// One-hot transition detector and binary encoder
module fti_encoder
  import fti_pkg::*;
(
  input  wire fti_pkg::fti_therm_t  therm,
  output      fti_pkg::fti_result_t code
);
  import fti_pkg::*;

  function automatic fti_result_t fti_encode(input fti_therm_t t);
    fti_therm_t  hot;
    fti_result_t r;
    int unsigned n;
    hot = '0;
    r   = FTI_RES_ZERO;
    n   = 0;
    for (int i = 0; i < FTI_STAGES; i++) begin
      if (i == FTI_STAGES - 1) begin
        hot[i] = t[i];
      end else begin
        hot[i] = t[i] & ~t[i+1];
      end
    end
    for (int i = 0; i < FTI_STAGES; i++) begin
      if (hot[i]) begin
        n = n + 1;
        r = fti_result_t'(i + 1);
      end
    end
    if (n != 1) begin
      r = FTI_RES_ZERO;
    end
    return r;
  endfunction : fti_encode

  assign code = fti_encode(therm);
endmodule : fti_encoder

//--- fti_channel.sv
// One interpolator channel: synchronizer, sampling chain, encoder, latch
module fti_channel
  import fti_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 event_in,
  output      logic                 gate_out,
  output      logic                 counter_trigger,
  output      logic                 result_valid,
  output      fti_pkg::fti_result_t result
);
  import fti_pkg::*;

  fti_state_t  state_q;
  logic        arm_q;
  logic        sync_clock_strobe_q;
  logic [FTI_STEPS-1:0] delayed_event_edge_q;
  fti_therm_t  therm_d;
  fti_therm_t  therm_q;
  fti_result_t code;
  logic        gate_q;
  logic        trig_q;
  logic        valid_q;
  fti_result_t result_q;

  // ==========================================================
  // Synchronizer: arm on event, strobe at next edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FTI_IDLE;
    end else begin
      unique case (state_q)
        FTI_IDLE:  if (event_in) state_q <= FTI_ARMED;
        FTI_ARMED: state_q <= FTI_RACE;
        FTI_RACE:  if (delayed_event_edge_q[FTI_STEPS-1])
                     state_q <= FTI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_clock_strobe_q <= 1'b0;
      arm_q               <= 1'b0;
    end else begin
      arm_q               <= (state_q == FTI_IDLE) && event_in;
      sync_clock_strobe_q <= arm_q;
    end
  end

  // ==========================================================
  // Event edge walks the chain one step per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayed_event_edge_q <= '0;
    end else begin
      delayed_event_edge_q <= {delayed_event_edge_q[FTI_STEPS-2:0],
                               arm_q};
    end
  end

  // Stages sample event edge when strobe fires; the encoder reads the
  // Value being captured so the result latches in the same cycle
  assign therm_d = event_in ? fti_therm_t'('1)
                            : delayed_event_edge_q[FTI_STAGES-1:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      therm_q <= '0;
    end else if (sync_clock_strobe_q) begin
      therm_q <= therm_d;
    end
  end

  fti_encoder u_enc (
    .therm (therm_d),
    .code  (code)
  );

  // ==========================================================
  // Outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q   <= 1'b0;
      trig_q   <= 1'b0;
      valid_q  <= 1'b0;
      result_q <= FTI_RES_ZERO;
    end else begin
      gate_q  <= (state_q == FTI_IDLE) && event_in;
      trig_q  <= arm_q;
      valid_q <= sync_clock_strobe_q;
      if (sync_clock_strobe_q) begin
        result_q <= code;
      end
    end
  end

  assign gate_out        = gate_q;
  assign counter_trigger = trig_q;
  assign result_valid    = valid_q;
  assign result          = result_q;

  // ==========================================================
  // Checks
  sequence s_accept;
    (state_q == FTI_IDLE) && event_in;
  endsequence

  sequence s_answer;
    gate_out ##1 counter_trigger ##1 result_valid;
  endsequence

  a_trig_leads: assert property (
    @(posedge clk) disable iff (rst) arm_q |=> counter_trigger)
    else $error("trigger missing");
  a_gate_copy: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == FTI_IDLE && event_in) |=> gate_out)
    else $error("gate missing");
  a_answer_order: assert property (
    @(posedge clk) disable iff (rst) s_accept |=> s_answer)
    else $error("gate, trigger, valid out of order");
  a_busy_refuse: assert property (
    @(posedge clk) disable iff (rst) (state_q != FTI_IDLE) |=> !gate_out)
    else $error("event accepted while busy");
  a_strobe_next: assert property (
    @(posedge clk) disable iff (rst) arm_q |=> sync_clock_strobe_q)
    else $error("strobe missing after arm");
  a_sync_release: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == FTI_ARMED) |-> ##11 (state_q == FTI_IDLE))
    else $error("synchronizer not released");
  a_lead_full: assert property (
    @(posedge clk) disable iff (rst)
    (sync_clock_strobe_q && event_in) |=>
      (therm_q == '1) && (result == fti_result_t'(FTI_STAGES)))
    else $error("leading event not full scale");
  a_valid_follows: assert property (
    @(posedge clk) disable iff (rst) sync_clock_strobe_q |=> result_valid)
    else $error("result valid missing");
endmodule : fti_channel

//--- fti_top.sv
// Dual interpolator: start and stop channels
// Overview of operation
// - Gate output pulses once for each start event accepted while idle
// - Strobe triggers timing counter on rising edge
// - Counter trigger leads reference edge
// - Period split into ten by nine stages
// - Event edge delayed one step per stage
// - Stages clocked by strobe sample event
// - One when event leads, zero when lags
// - Stage outputs form thermometer code
// - Stage ANDed with next inverted stage
// - Encoder turns one-hot into binary
// - Each result unit is one step
// - Four parallel result bits presented
// - Result delivered after each conversion
// - Two identical channels, start and stop
// - Event arms synchronizer, next edge strobes
// - Delayed edge resets synchronizer at end
module fti_top
  import fti_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 start_event,
  input  wire logic                 stop_event,
  output      logic                 sample_gate,
  output      logic                 first_counter_trigger,
  output      logic                 last_counter_trigger,
  output      logic                 start_valid,
  output      fti_pkg::fti_result_t start_result,
  output      logic                 stop_valid,
  output      fti_pkg::fti_result_t stop_result
);
  import fti_pkg::*;

  fti_channel u_start (
    .clk             (clk),
    .rst             (rst),
    .event_in        (start_event),
    .gate_out        (sample_gate),
    .counter_trigger (first_counter_trigger),
    .result_valid    (start_valid),
    .result          (start_result)
  );

  fti_channel u_stop (
    .clk             (clk),
    .rst             (rst),
    .event_in        (stop_event),
    .gate_out        (),
    .counter_trigger (last_counter_trigger),
    .result_valid    (stop_valid),
    .result          (stop_result)
  );
endmodule : fti_top

//--- fti_seq_model.sv
// Sequencer, timing counter and result store facing the interpolator
module fti_seq_model
  import fti_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 arm_start,
  input  wire logic                 arm_stop,
  input  wire logic                 first_counter_trigger,
  input  wire logic                 last_counter_trigger,
  input  wire logic                 start_valid,
  input  wire fti_pkg::fti_result_t start_result,
  input  wire logic                 stop_valid,
  input  wire fti_pkg::fti_result_t stop_result,
  output      logic                 start_event,
  output      logic                 stop_event,
  output      logic [7:0]           count_q,
  output      fti_pkg::fti_result_t start_store_q,
  output      fti_pkg::fti_result_t stop_store_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import fti_pkg::*;
  logic run_q;
  // Events pass straight through from the arm inputs
  assign start_event = arm_start;
  assign stop_event  = arm_stop;
  // ==========================================================
  // Timing counter, one count per clock cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      count_q <= 8'h00;
    end else if (first_counter_trigger) begin
      run_q   <= 1'b1;
      count_q <= 8'h00;
    end else if (last_counter_trigger) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      count_q <= count_q + 8'h01;
    end
  end
  // ==========================================================
  // Result store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_store_q <= FTI_RES_ZERO;
      stop_store_q  <= FTI_RES_ZERO;
    end else begin
      if (start_valid) start_store_q <= start_result;
      if (stop_valid) stop_store_q <= stop_result;
    end
  end
endmodule : fti_seq_model

//--- tb_flash_time_interpolator.sv
// Self-checking bench for the dual interpolator
module tb_flash_time_interpolator;
  timeunit 1ns;
  timeprecision 1ps;
  import fti_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        arm_s = 1'b0;
  logic        arm_p = 1'b0;
  logic        sev, pev, gate, t1, t2, v1, v2;
  fti_result_t r1, r2, s1, s2;
  logic [7:0]  cnt;
  int          n_errors = 0;
  int          compares = 0;
  always #10 clk = ~clk;
  fti_top dut (.clk(clk), .rst(rst), .start_event(sev), .stop_event(pev),
    .sample_gate(gate), .first_counter_trigger(t1),
    .last_counter_trigger(t2), .start_valid(v1), .start_result(r1),
    .stop_valid(v2), .stop_result(r2));
  fti_seq_model seq (.clk(clk), .rst(rst), .arm_start(arm_s),
    .arm_stop(arm_p), .first_counter_trigger(t1),
    .last_counter_trigger(t2), .start_valid(v1), .start_result(r1),
    .stop_valid(v2), .stop_result(r2), .start_event(sev),
    .stop_event(pev), .count_q(cnt), .start_store_q(s1),
    .stop_store_q(s2));
  task automatic chk(input string n, input logic [7:0] seen, e);
    compares++;
    if (seen !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Event held three cycles so it still leads the strobe: full chain
  task automatic fire(input logic s, input logic p);
    @(posedge clk);
    #1 arm_s = s;
    arm_p = p;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1;
      chk("gate", gate, k == 0 && s);
      chk("trig1", t1, k == 1 && s);
      chk("trig2", t2, k == 1 && p);
      chk("valid1", v1, k == 2 && s);
      chk("valid2", v2, k == 2 && p);
      if (k == 2) begin
        arm_s = 1'b0;
        arm_p = 1'b0;
      end
    end
    if (s) chk("res1", r1, 8'h09);
    if (p) chk("res2", r2, 8'h09);
    repeat (14) @(posedge clk);
  endtask : fire
  // A long event must not retrigger a busy channel
  task automatic hold_busy;
    int g = 0;
    @(posedge clk);
    #1 arm_s = 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 g += sample_gate_bit();
    end
    arm_s = 1'b0;
    chk("gates", g[7:0], 8'h01);
    repeat (14) @(posedge clk);
  endtask : hold_busy
  // Event gone before the strobe: only the first stage sees it
  task automatic short_event;
    @(posedge clk);
    #1 arm_s = 1'b1;
    @(posedge clk);
    #1 arm_s = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("short", r1, 8'h01);
    chk("store_short", s1, 8'h01);
    repeat (14) @(posedge clk);
  endtask : short_event
  function automatic int sample_gate_bit();
    return (gate === 1'b1) ? 1 : 0;
  endfunction : sample_gate_bit
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    fire(1'b1, 1'b0);
    chk("store1", s1, 8'h09);
    fire(1'b0, 1'b1);
    chk("count", cnt, 8'h12);
    chk("store2", s2, 8'h09);
    fire(1'b1, 1'b1);
    hold_busy;
    short_event;
    tally_and_finish;
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule : tb_flash_time_interpolator
